// [core/irm_ctrl.sv]
// Interrupt entry, return, nesting and low-power mode controller.
`include "irm_defines.svh"
`default_nettype none
module irm_ctrl
  import irm_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Interrupt requests, already gated by their own enables
  input wire logic [15:0] IRQ_REQ,
  input wire logic [15:0] IRQ_MULTI_SRC,
  input wire logic PIN_EVENT_FLAG,
  input wire logic OSC_FAULT_FLAG,
  input wire logic FLASH_VIOLATION_FLAG,
  // Core sequencer
  input wire logic INSTR_BOUNDARY,
  input wire logic RETURN_FROM_INTERRUPT_INSTR,
  input wire logic [15:0] PROGRAM_COUNTER,
  input wire logic SW_WRITE,
  input wire logic [15:0] SW_WDATA,
  input wire logic [15:0] STACK_RDATA,
  input wire logic OSC_FEEDS_CLOCKS,
  // Stack access
  output logic STACK_PUSH,
  output logic STACK_POP,
  output logic [15:0] STACK_WDATA,
  // Vector fetch and results
  output logic [15:0] VECTOR_ADDR,
  output logic LOAD_VECTOR,
  output logic LOAD_PC,
  output logic [15:0] PC_OUT,
  output logic [15:0] IRQ_ACK,
  output logic NMI_SHARED_ACK,
  output logic [15:0] STATUS_WORD,
  output logic IN_SEQUENCE,
  // Clock gating
  output logic CORE_RUN,
  output logic MAIN_CLK_EN,
  output logic SUBSYSTEM_CLK_EN,
  output logic AUX_CLK_EN,
  output logic OSC_EN,
  output logic DC_GEN_EN,
  output logic BYTE_ONLY_SFR
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    irm_state_e st;
    logic [2:0] cnt;
    logic [15:0] sw;
    logic [3:0] slot;
    logic [15:0] ack;
    logic push;
    logic pop;
    logic [15:0] wdata;
    logic load_vec;
    logic load_pc;
    logic [15:0] pc;
    logic [15:0] vaddr;
  } irm_state_s;

  irm_state_s q;
  irm_state_s d;
  logic rst_a;
  logic rst_b;
  logic any;
  logic [3:0] slot;
  logic [15:0] masked;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_a <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_b <= rst_a;
    end
  end

  // ************************************************************
  // Request selection
  // ************************************************************
  // Slots 14 and 15 ignore global enable; the rest need it. A set enable
  // admits any request even inside a routine, whatever its priority.
  always_comb begin
    masked = IRQ_REQ & (q.sw[`IRM_SW_IRQ_EN] ? 16'hffff : 16'hc000);
  end

  irm_prio u_prio (
    .req(masked),
    .any(any),
    .slot(slot)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    d = q;
    d.push = 1'b0;
    d.pop = 1'b0;
    d.load_vec = 1'b0;
    d.load_pc = 1'b0;
    d.ack = 16'h0000;
    case (q.st)
      IRM_RUN: begin
        // Mode bit writes land directly in the status word.
        if (SW_WRITE) begin
          d.sw = SW_WDATA;
        end
        // An asleep core still accepts; boundary is implied when stopped.
        if (any && (INSTR_BOUNDARY || q.sw[`IRM_SW_CORE_OFF])) begin
          d.st = IRM_ENTRY;
          d.slot = slot;
          d.cnt = 3'h1;
          d.pc = PROGRAM_COUNTER;
        end else if (RETURN_FROM_INTERRUPT_INSTR && INSTR_BOUNDARY) begin
          d.st = IRM_RETURN;
          d.cnt = 3'h1;
        end
      end
      IRM_ENTRY: begin
        d.cnt = q.cnt + 3'h1;
        case (q.cnt)
          3'h1: begin
            d.push = 1'b1;
            d.wdata = q.pc;
          end
          3'h2: begin
            d.push = 1'b1;
            d.wdata = q.sw;
          end
          3'h3: begin
            // Gate 0 survives; the other mode bits and enable are cleared.
            d.sw = q.sw & (16'h0001 << `IRM_SW_GATE0);
            d.ack = (16'h0001 << q.slot) & ~IRQ_MULTI_SRC;
          end
          3'h4: begin
            d.vaddr = `IRM_VEC_BASE | {11'h000, q.slot, 1'b0};
            d.load_vec = 1'b1;
          end
          default: begin
            if (q.cnt >= `IRM_ENTRY_CYCLES) begin
              d.st = IRM_RUN;
              d.cnt = 3'h0;
            end
          end
        endcase
      end
      IRM_RETURN: begin
        d.cnt = q.cnt + 3'h1;
        case (q.cnt)
          // Read data trails each pop by one cycle.
          3'h1: d.pop = 1'b1;
          3'h2: d.pop = 1'b1;
          3'h3: begin
            d.sw = STACK_RDATA;
          end
          3'h4: begin
            d.pc = STACK_RDATA;
            d.load_pc = 1'b1;
          end
          default: begin
            if (q.cnt >= `IRM_RETURN_CYCLES) begin
              d.st = IRM_RUN;
              d.cnt = 3'h0;
            end
          end
        endcase
      end
      default: d.st = IRM_RUN;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{st: IRM_RUN, sw: `IRM_SW_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs and clock gating
  // ************************************************************
  always_comb begin
    logic coff;
    logic ooff;
    logic g0;
    logic g1;
    coff = q.sw[`IRM_SW_CORE_OFF];
    ooff = q.sw[`IRM_SW_OSC_OFF];
    g0 = q.sw[`IRM_SW_GATE0];
    g1 = q.sw[`IRM_SW_GATE1];
    STACK_PUSH = q.push;
    STACK_POP = q.pop;
    STACK_WDATA = q.wdata;
    VECTOR_ADDR = q.vaddr;
    LOAD_VECTOR = q.load_vec;
    LOAD_PC = q.load_pc;
    PC_OUT = q.pc;
    IRQ_ACK = q.ack;
    // Shared slot keeps its three flags; software reads them to tell apart.
    NMI_SHARED_ACK = q.ack[`IRM_VEC_NMI] | (q.load_vec && q.slot == `IRM_VEC_NMI
      && (PIN_EVENT_FLAG | OSC_FAULT_FLAG | FLASH_VIOLATION_FLAG));
    STATUS_WORD = q.sw;
    IN_SEQUENCE = (q.st != IRM_RUN);
    // Gating follows the live status word; clocks gated leave state intact.
    CORE_RUN = !coff || (q.st != IRM_RUN);
    MAIN_CLK_EN = !coff || (q.st != IRM_RUN);
    SUBSYSTEM_CLK_EN = !(coff && g1) && !ooff;
    AUX_CLK_EN = !ooff;
    OSC_EN = !(coff && (g0 || g1)) && !ooff;
    DC_GEN_EN = !ooff && !(coff && g0 && g1) &&
      !(coff && g0 && !g1 && !OSC_FEEDS_CLOCKS);
    BYTE_ONLY_SFR = 1'b1;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence entry_start_s;
    q.st == IRM_RUN && d.st == IRM_ENTRY;
  endsequence

  property entry_push_p;
    @(posedge CORE_CLK) disable iff (!rst_b)
      entry_start_s |=> ##1 STACK_PUSH ##1 STACK_PUSH ##1 !STACK_PUSH;
  endproperty
  entry_push_a: assert property (entry_push_p)
    else $error("entry stacking order wrong");

  entry_length_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    entry_start_s |=> (q.st == IRM_ENTRY) [*6] ##1 q.st == IRM_RUN)
    else $error("entry not six cycles");

  entry_clear_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    q.st == IRM_ENTRY && q.cnt == 3'h3 |=> !STATUS_WORD[`IRM_SW_CORE_OFF] &&
      !STATUS_WORD[`IRM_SW_GATE1] && !STATUS_WORD[`IRM_SW_OSC_OFF] &&
      !STATUS_WORD[`IRM_SW_IRQ_EN])
    else $error("mode bits not cleared on entry");

  gate0_keep_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    q.st == IRM_ENTRY && q.cnt == 3'h3 |=> $stable(STATUS_WORD[`IRM_SW_GATE0]))
    else $error("gate 0 bit changed on entry");

  return_len_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    q.st == IRM_RUN && d.st == IRM_RETURN |=> (q.st == IRM_RETURN) [*5]
      ##1 q.st == IRM_RUN)
    else $error("return not five cycles");

  return_sw_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    q.st == IRM_RETURN && q.cnt == 3'h3 |=> STATUS_WORD == $past(STACK_RDATA))
    else $error("status word not restored");

  vector_addr_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    LOAD_VECTOR |-> VECTOR_ADDR == (`IRM_VEC_BASE | {11'h000, q.slot, 1'b0}))
    else $error("vector address wrong");

  write_now_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    q.st == IRM_RUN && SW_WRITE && !d.st[0] |=> STATUS_WORD == $past(SW_WDATA))
    else $error("mode write delayed");

  all_stopped_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)
    STATUS_WORD[`IRM_SW_OSC_OFF] |-> !AUX_CLK_EN && !SUBSYSTEM_CLK_EN && !OSC_EN)
    else $error("clock running with oscillator off");
endmodule : irm_ctrl
`default_nettype wire

// [core/irm_defines.svh]
// Constants for the interrupt return and low-power mode controller.
`ifndef IRM_DEFINES_SVH
`define IRM_DEFINES_SVH
// Status word bit positions.
`define IRM_SW_IRQ_EN 3
`define IRM_SW_CORE_OFF 4
`define IRM_SW_OSC_OFF 5
`define IRM_SW_GATE0 6
`define IRM_SW_GATE1 7
// Vector table.
`define IRM_VEC_BASE 16'hffe0
`define IRM_VEC_RESET 4'hf
`define IRM_VEC_NMI 4'he
`define IRM_VEC_WDT 4'ha
// Sequence lengths in cycles, and the status word reset value.
`define IRM_ENTRY_CYCLES 3'h6
`define IRM_RETURN_CYCLES 3'h5
`define IRM_SW_RESET 16'h0000
`endif

// [core/irm_pkg.sv]
// Types for the interrupt return and low-power mode controller.
`default_nettype none
package irm_pkg;
  typedef enum logic [2:0] {
    IRM_RUN = 3'h0,
    IRM_ENTRY = 3'h1,
    IRM_RETURN = 3'h3
  } irm_state_e;
  typedef logic [15:0] irm_word_t;
endpackage : irm_pkg
`default_nettype wire

// [core/irm_prio.sv]
// Fixed-priority picker over sixteen vector slots.
`default_nettype none
module irm_prio (
  // Requests
  input wire logic [15:0] req,
  // Choice
  output logic any,
  output logic [3:0] slot
);
  always_comb begin
    any = 1'b0;
    slot = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (req[i]) begin
        any = 1'b1;
        slot = i[3:0];
      end
    end
  end
endmodule : irm_prio
`default_nettype wire

// [verif/irm_stack_model.sv]
// Stack memory on the core side of the interrupt controller.
`default_nettype none
module irm_stack_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stack requests
  input wire logic push,
  input wire logic pop,
  input wire logic [15:0] wdata,
  // Service routine overwrite of the top entry
  input wire logic edit_en,
  input wire logic [15:0] edit,
  // Read data
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [8];
  logic [2:0] sp;
  // Read data is valid only the cycle after a pop; otherwise it toggles.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= 3'h0;
      rdata <= 16'h0000;
    end else begin
      rdata <= ~rdata;
      if (push) begin
        mem[sp] <= wdata;
        sp <= sp + 3'h1;
      end else if (pop) begin
        rdata <= mem[sp - 3'h1];
        sp <= sp - 3'h1;
      end else if (edit_en) begin
        mem[sp - 3'h1] <= edit;
      end
    end
  end
endmodule : irm_stack_model
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the interrupt return and low-power mode controller.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n = 1'b0, bnd = 1'b1, ret_i = 1'b0, sw_we = 1'b0, osc_src = 1'b0;
  logic edit_en = 1'b0, nseen = 1'b0, clr = 1'b0;
  logic push, pop, lvec, lpc, nack, inseq, special_function_regs;
  logic [2:0] nmi_f = 3'h0;
  logic [5:0] clks;
  logic [15:0] irq_req = 16'h0000, multi = 16'h4008, pc = 16'h1234, sw_wd = 16'h0000;
  logic [15:0] edit = 16'h0000, acks = 16'h0000;
  logic [15:0] srd, swd, vaddr, pco, ack, sw;
  int n_mismatch = 0, compares = 0, cnt;
  irm_ctrl dut (.CORE_CLK(clk), .RST_N(rst_n), .IRQ_REQ(irq_req), .IRQ_MULTI_SRC(multi),
    .PIN_EVENT_FLAG(nmi_f[0]), .OSC_FAULT_FLAG(nmi_f[1]), .FLASH_VIOLATION_FLAG(nmi_f[2]),
    .INSTR_BOUNDARY(bnd), .RETURN_FROM_INTERRUPT_INSTR(ret_i), .PROGRAM_COUNTER(pc),
    .SW_WRITE(sw_we), .SW_WDATA(sw_wd), .STACK_RDATA(srd), .OSC_FEEDS_CLOCKS(osc_src),
    .STACK_PUSH(push), .STACK_POP(pop), .STACK_WDATA(swd), .VECTOR_ADDR(vaddr),
    .LOAD_VECTOR(lvec), .LOAD_PC(lpc), .PC_OUT(pco), .IRQ_ACK(ack), .NMI_SHARED_ACK(nack),
    .STATUS_WORD(sw), .IN_SEQUENCE(inseq), .CORE_RUN(clks[5]), .MAIN_CLK_EN(clks[4]),
    .SUBSYSTEM_CLK_EN(clks[3]), .AUX_CLK_EN(clks[2]), .OSC_EN(clks[1]), .DC_GEN_EN(clks[0]),
    .BYTE_ONLY_SFR(special_function_regs));
  irm_stack_model stk (.clk(clk), .rst_n(rst_n), .push(push), .pop(pop), .wdata(swd),
    .edit_en(edit_en), .edit(edit), .rdata(srd));
  always @(posedge clk) begin
    if (clr) begin
      acks <= 16'h0000;
      nseen <= 1'b0;
    end else begin
      acks <= acks | ack;
      nseen <= nseen | nack;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  // Waits for the vector load (0), the PC load (1) or the sequence end (2).
  task automatic wait_on(input int w);
    for (cnt = 0; cnt < 50; cnt++) begin
      tick();
      if (w == 0 ? lvec === 1'b1 : w == 1 ? lpc === 1'b1 : inseq === 1'b0) break;
    end
    if (cnt == 50) begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_on
  task automatic sw_write(input logic [15:0] v);
    sw_wd = v;
    sw_we = 1'b1;
    tick();
    sw_we = 1'b0;
  endtask : sw_write
  task automatic take(input logic [15:0] req, input logic [15:0] at, input logic [3:0] s);
    pc = at;
    clr = 1'b1;
    tick();
    clr = 1'b0;
    irq_req = req;
    wait_on(0);
    chk("entry cycles", 16'(cnt), 16'h0004);
    chk("vector", vaddr, 16'hffe0 + {11'h000, s, 1'b0});
    irq_req = 16'h0000;
    wait_on(2);
    chk("ack", acks, multi[s] ? 16'h0000 : 16'h0001 << s);
  endtask : take
  task automatic ret(input logic [15:0] at, input logic [15:0] st);
    ret_i = 1'b1;
    tick();
    ret_i = 1'b0;
    wait_on(1);
    chk("return cycles", 16'(cnt), 16'h0003);
    chk("pc", pco, at);
    wait_on(2);
    chk("status", sw, st);
  endtask : ret
  task automatic modes();
    logic [7:0] sw_t [7] = '{8'h00, 8'h10, 8'h50, 8'h50, 8'h90, 8'hd0, 8'hf0};
    logic [5:0] ex_t [7] = '{6'h3f, 6'h0f, 6'h0c, 6'h0d, 6'h05, 6'h04, 6'h00};
    for (int i = 0; i < 7; i++) begin
      osc_src = (i == 3);
      sw_write({8'h00, sw_t[i]});
      chk("clocks", {10'h000, clks}, {10'h000, ex_t[i]});
      chk("mode", sw, {8'h00, sw_t[i]});
    end
  endtask : modes
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(4);
    chk("reset status", sw, 16'h0000);
    chk("sfr", {15'h0000, special_function_regs}, 16'h0001);
    modes();
    sw_write(16'h00d8);
    take(16'h0408, 16'h1234, 4'ha);
    chk("entry status", sw, 16'h0040);
    chk("awake", {15'h0000, clks[5]}, 16'h0001);
    ret(16'h1234, 16'h00d8);
    take(16'h1000, 16'h2000, 4'hc);
    edit = 16'h0008;
    edit_en = 1'b1;
    tick();
    edit_en = 1'b0;
    ret(16'h2000, 16'h0008);
    take(16'h1000, 16'h3000, 4'hc);
    sw_write(16'h0008);
    take(16'h0004, 16'h3100, 4'h2);
    for (int k = 0; k < 3; k++) begin
      nmi_f = 3'h1 << k;
      take(16'h4000, 16'h3200, 4'he);
      nmi_f = 3'h0;
      chk("shared ack", {15'h0000, nseen}, 16'h0001);
      ret(16'h3200, 16'h0000);
    end
    ret(16'h3100, 16'h0008);
    ret(16'h3000, 16'h0008);
    close_out();
  end
endmodule : testbench
`default_nettype wire
